// >>> src/crf_pkg.sv
package crf_pkg;
	localparam int DATA_W = 16;
	localparam int WIDE_W = 20;
	localparam int FLAG_W = 11;
	localparam int NUM_BANKS = 2;
	localparam int BANK_REGS = 7;

	// ------------------------------------------------------------
	// Flag field positions
	// ------------------------------------------------------------
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_DEBUG = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_SIGN = 3;
	localparam int FLAG_BANK = 4;
	localparam int FLAG_OVF = 5;
	localparam int FLAG_IE = 6;
	localparam int FLAG_STK = 7;
	localparam int PRIO_LSB = 8;
	localparam int PRIO_MSB = 10;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [19:0] WIDE_RST = 20'h0_0000;
	localparam logic [10:0] FLAG_RST = 11'h000;

	// ------------------------------------------------------------
	// Register indices, shared by core select and bus decode
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_DATA0 = 4'h0;
	localparam logic [3:0] IDX_DATA1 = 4'h1;
	localparam logic [3:0] IDX_DATA2 = 4'h2;
	localparam logic [3:0] IDX_DATA3 = 4'h3;
	localparam logic [3:0] IDX_ADDR0 = 4'h4;
	localparam logic [3:0] IDX_ADDR1 = 4'h5;
	localparam logic [3:0] IDX_FRAME = 4'h6;
	localparam logic [3:0] IDX_VECT = 4'h7;
	localparam logic [3:0] IDX_PC = 4'h8;
	localparam logic [3:0] IDX_USER_STK = 4'h9;
	localparam logic [3:0] IDX_IRQ_STK = 4'hA;
	localparam logic [3:0] IDX_STATIC = 4'hB;
	localparam logic [3:0] IDX_FLAGS = 4'hC;
	localparam logic [3:0] IDX_SP = 4'hD;

	// Byte lane modes and long pair selects
	localparam logic [1:0] BYTE_WORD = 2'h0;
	localparam logic [1:0] BYTE_LOW = 2'h1;
	localparam logic [1:0] BYTE_HIGH = 2'h2;
	localparam logic [1:0] LSEL_DATA_LOW = 2'h0;
	localparam logic [1:0] LSEL_DATA_HIGH = 2'h1;
	localparam logic [1:0] LSEL_ADDR = 2'h2;

	localparam logic [5:0] SWI_LOW_LIMIT = 6'h20;

	// ------------------------------------------------------------
	// Bus map: bank b register r at b*0x20 + r*4, shared from 0x40
	// ------------------------------------------------------------
	localparam logic [7:0] APB_SHARED_BASE = 8'h40;
	localparam logic [7:0] APB_LAST_OFF = 8'h58;
endpackage : crf_pkg

// >>> src/crf_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module crf_regfile (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic CORE_WE_I,
	input wire logic [3:0] CORE_SEL_I,
	input wire logic [1:0] CORE_BYTE_I,
	input wire logic [19:0] CORE_WDATA_I,
	input wire logic [3:0] CORE_RSEL_I,
	output logic [19:0] CORE_RDATA_O,
	input wire logic CORE_LONG_WE_I,
	input wire logic [1:0] CORE_LONG_SEL_I,
	input wire logic [31:0] CORE_LONG_WDATA_I,
	input wire logic PC_LOAD_I,
	input wire logic [19:0] PC_NEXT_I,
	input wire logic FLAG_WE_I,
	input wire logic [10:0] FLAG_WDATA_I,
	input wire logic ALU_UPD_I,
	input wire logic ALU_BYTE_I,
	input wire logic [15:0] ALU_RESULT_I,
	input wire logic ALU_CARRY_I,
	input wire logic ALU_OVF_I,
	input wire logic IRQ_REQ_I,
	input wire logic IRQ_MASKABLE_I,
	input wire logic [2:0] IRQ_LEVEL_I,
	output logic IRQ_ACCEPT_O,
	input wire logic IRQ_ACK_I,
	input wire logic SWI_EXEC_I,
	input wire logic [5:0] SWI_NUM_I,
	output logic [10:0] FLAGS_O,
	output logic [19:0] PC_O,
	output logic [19:0] VECTOR_BASE_O,
	output logic [15:0] STATIC_BASE_O,
	output logic [15:0] FRAME_BASE_O,
	output logic [15:0] ACTIVE_SP_O,
	output logic [31:0] LONG_DATA_LOW_O,
	output logic [31:0] LONG_DATA_HIGH_O,
	output logic [31:0] LONG_ADDR_O
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0] bank_w [0:1][0:6];
	logic [10:0] flags_q;
	logic [19:0] vect_q;
	logic [19:0] pc_q;
	logic [15:0] user_stk_q;
	logic [15:0] irq_stk_q;
	logic [15:0] static_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [19:0] core_rdata_q;
	logic bank_sel;
	logic stack_sel;
	logic [2:0] prio_lvl;
	logic apb_wr;
	logic [5:0] wr_dec;
	logic [5:0] rd_dec;
	logic alu_zero;
	logic alu_sign;
	logic swi_low;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Returns {valid, bank, index}
	function automatic logic [5:0] apb_decode(input logic [7:0] addr);
		logic [5:0] res;
		res = 6'h00;
		if ((addr[1:0] == 2'h0) && (addr <= crf_pkg::APB_LAST_OFF))
		begin
			if (addr < crf_pkg::APB_SHARED_BASE)
			begin
				if (addr[4:2] != 3'h7)
				begin
					res = {1'b1, addr[5], 1'b0, addr[4:2]};
				end
			end
			else
			begin
				res = {2'b10, crf_pkg::IDX_VECT + {1'b0, addr[4:2]}};
			end
		end
		return res;
	endfunction : apb_decode

	function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] mode);
		logic [15:0] res;
		res = new_v;
		if (mode == crf_pkg::BYTE_LOW)
		begin
			res = {old_v[15:8], new_v[7:0]};
		end
		else if (mode == crf_pkg::BYTE_HIGH)
		begin
			res = {new_v[7:0], old_v[7:0]};
		end
		return res;
	endfunction : merge_bytes

	// Read mux shared by the bus and the core read port
	function automatic logic [19:0] read_reg(input logic bk, input logic [3:0] idx);
		logic [19:0] res;
		res = 20'h0_0000;
		case (idx)
			crf_pkg::IDX_VECT: res = vect_q;
			crf_pkg::IDX_PC: res = pc_q;
			crf_pkg::IDX_USER_STK: res = {4'h0, user_stk_q};
			crf_pkg::IDX_IRQ_STK: res = {4'h0, irq_stk_q};
			crf_pkg::IDX_STATIC: res = {4'h0, static_q};
			crf_pkg::IDX_FLAGS: res = {9'h000, flags_q};
			crf_pkg::IDX_SP: res = {4'h0, ACTIVE_SP_O};
			default:
			begin
				if (idx < crf_pkg::IDX_VECT)
				begin
					res = {4'h0, bank_w[bk][idx[2:0]]};
				end
			end
		endcase
		return res;
	endfunction : read_reg

	assign bank_sel = flags_q[crf_pkg::FLAG_BANK];
	assign stack_sel = flags_q[crf_pkg::FLAG_STK];
	assign prio_lvl = flags_q[crf_pkg::PRIO_MSB:crf_pkg::PRIO_LSB];
	assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign wr_dec = apb_decode(PADDR_I);
	assign rd_dec = apb_decode(PADDR_I);

	// ------------------------------------------------------------
	// Banked registers
	// ------------------------------------------------------------
	// two banks of seven
	genvar gb;
	genvar gr;
	generate
		for (gb = 0; gb < crf_pkg::NUM_BANKS; gb++)
		begin : g_bank
			for (gr = 0; gr < crf_pkg::BANK_REGS; gr++)
			begin : g_reg
				localparam logic [3:0] RI = 4'(gr);
				localparam logic BI = 1'(gb);
				localparam logic [1:0] LS = (gr == 0 || gr == 2) ? crf_pkg::LSEL_DATA_LOW :
					(gr == 1 || gr == 3) ? crf_pkg::LSEL_DATA_HIGH : crf_pkg::LSEL_ADDR;
				localparam bit UPPER = (gr == 2 || gr == 3 || gr == 5);
				localparam bit PAIRED = (gr < 6);
				localparam bit SPLIT = (gr < 2);
				logic [15:0] val_q;
				logic core_hit;
				logic long_hit;
				logic apb_hit;
				assign core_hit = CORE_WE_I && (CORE_SEL_I == RI) && (bank_sel == BI);
				assign long_hit = PAIRED && CORE_LONG_WE_I && (CORE_LONG_SEL_I == LS) &&
					(bank_sel == BI);
				assign apb_hit = apb_wr && wr_dec[5] && (wr_dec[4] == BI) &&
					(wr_dec[3:0] == RI);
				always_ff @(posedge CLK_I or negedge RSTN_I)
				begin
					if (!RSTN_I)
					begin
						val_q <= crf_pkg::REG_RST;
					end
					else if (core_hit)
					begin
						val_q <= SPLIT ? merge_bytes(val_q, CORE_WDATA_I[15:0], CORE_BYTE_I) :
							CORE_WDATA_I[15:0];
					end
					else if (long_hit)
					begin
						val_q <= UPPER ? CORE_LONG_WDATA_I[31:16] : CORE_LONG_WDATA_I[15:0];
					end
					else if (apb_hit)
					begin
						val_q <= PWDATA_I[15:0];
					end
				end
				assign bank_w[gb][gr] = val_q;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Shared registers
	// ------------------------------------------------------------
	// shared, not banked
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			vect_q <= crf_pkg::WIDE_RST;
		else if (CORE_WE_I && CORE_SEL_I == crf_pkg::IDX_VECT)
			vect_q <= CORE_WDATA_I;
		else if (apb_wr && wr_dec[5] && wr_dec[3:0] == crf_pkg::IDX_VECT)
			vect_q <= PWDATA_I[19:0];
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			pc_q <= crf_pkg::WIDE_RST;
		else if (PC_LOAD_I)
			pc_q <= PC_NEXT_I;
		else if (CORE_WE_I && CORE_SEL_I == crf_pkg::IDX_PC)
			pc_q <= CORE_WDATA_I;
		else if (apb_wr && wr_dec[5] && wr_dec[3:0] == crf_pkg::IDX_PC)
			pc_q <= PWDATA_I[19:0];
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			user_stk_q <= crf_pkg::REG_RST;
		else if (CORE_WE_I && (CORE_SEL_I == crf_pkg::IDX_USER_STK ||
			(CORE_SEL_I == crf_pkg::IDX_SP && stack_sel)))
			user_stk_q <= CORE_WDATA_I[15:0];
		else if (apb_wr && wr_dec[5] && wr_dec[3:0] == crf_pkg::IDX_USER_STK)
			user_stk_q <= PWDATA_I[15:0];
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			irq_stk_q <= crf_pkg::REG_RST;
		else if (CORE_WE_I && (CORE_SEL_I == crf_pkg::IDX_IRQ_STK ||
			(CORE_SEL_I == crf_pkg::IDX_SP && !stack_sel)))
			irq_stk_q <= CORE_WDATA_I[15:0];
		else if (apb_wr && wr_dec[5] && wr_dec[3:0] == crf_pkg::IDX_IRQ_STK)
			irq_stk_q <= PWDATA_I[15:0];
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			static_q <= crf_pkg::REG_RST;
		else if (CORE_WE_I && CORE_SEL_I == crf_pkg::IDX_STATIC)
			static_q <= CORE_WDATA_I[15:0];
		else if (apb_wr && wr_dec[5] && wr_dec[3:0] == crf_pkg::IDX_STATIC)
			static_q <= PWDATA_I[15:0];
	end

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	assign alu_zero = ALU_BYTE_I ? (ALU_RESULT_I[7:0] == 8'h00) : (ALU_RESULT_I == 16'h0000);
	assign alu_sign = ALU_BYTE_I ? ALU_RESULT_I[7] : ALU_RESULT_I[15];
	assign swi_low = SWI_NUM_I < crf_pkg::SWI_LOW_LIMIT;

	// Later assignments win: hardware events override writes
	// eleven-bit flag state
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			flags_q <= crf_pkg::FLAG_RST;
		end
		else
		begin
			if (apb_wr && wr_dec[5] && wr_dec[3:0] == crf_pkg::IDX_FLAGS)
				flags_q <= PWDATA_I[10:0];
			if (FLAG_WE_I)
				flags_q <= FLAG_WDATA_I;
			if (ALU_UPD_I)
			begin
				flags_q[crf_pkg::FLAG_CARRY] <= ALU_CARRY_I;
				flags_q[crf_pkg::FLAG_ZERO] <= alu_zero;
				flags_q[crf_pkg::FLAG_SIGN] <= alu_sign;
				flags_q[crf_pkg::FLAG_OVF] <= ALU_OVF_I;
			end
			if (IRQ_ACK_I || SWI_EXEC_I)
				flags_q[crf_pkg::FLAG_IE] <= 1'b0;
			if (IRQ_ACK_I || (SWI_EXEC_I && swi_low))
				flags_q[crf_pkg::FLAG_STK] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Bus slave: data captured in setup, so no wait states
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (PSEL_I && !PENABLE_I)
		begin
			prdata_q <= rd_dec[5] ? {12'h000, read_reg(rd_dec[4], rd_dec[3:0])} : 32'h0000_0000;
			pslverr_q <= !rd_dec[5];
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			core_rdata_q <= crf_pkg::WIDE_RST;
		else
			core_rdata_q <= read_reg(bank_sel, CORE_RSEL_I);
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign PRDATA_O = prdata_q;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = pslverr_q && PSEL_I && PENABLE_I;
	assign CORE_RDATA_O = core_rdata_q;
	assign FLAGS_O = flags_q;
	assign PC_O = pc_q;
	assign VECTOR_BASE_O = vect_q;
	assign STATIC_BASE_O = static_q;
	assign FRAME_BASE_O = bank_w[bank_sel][6];
	assign ACTIVE_SP_O = stack_sel ? user_stk_q : irq_stk_q;
	assign LONG_DATA_LOW_O = {bank_w[bank_sel][2], bank_w[bank_sel][0]};
	assign LONG_DATA_HIGH_O = {bank_w[bank_sel][3], bank_w[bank_sel][1]};
	assign LONG_ADDR_O = {bank_w[bank_sel][5], bank_w[bank_sel][4]};
	assign IRQ_ACCEPT_O = IRQ_REQ_I && (!IRQ_MASKABLE_I || flags_q[crf_pkg::FLAG_IE]) &&
		(IRQ_LEVEL_I > prio_lvl);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);

	chk_ack_clears_ie: assert property (IRQ_ACK_I |=> !FLAGS_O[6])
		else $error("interrupt enable not cleared after acknowledge");
	chk_ack_clears_sel: assert property (IRQ_ACK_I |=>
		!FLAGS_O[7] && ACTIVE_SP_O == irq_stk_q)
		else $error("stack select not cleared after acknowledge");
	chk_swi_low_sel: assert property (
		SWI_EXEC_I && SWI_NUM_I < crf_pkg::SWI_LOW_LIMIT |=> !FLAGS_O[7])
		else $error("low software interrupt kept user stack");
	chk_zero_flag: assert property (ALU_UPD_I |=> FLAGS_O[2] ==
		($past(ALU_BYTE_I) ? $past(ALU_RESULT_I[7:0]) == 8'h00 : $past(ALU_RESULT_I) == 16'h0000))
		else $error("zero flag does not match result");
	chk_sign_flag: assert property (ALU_UPD_I && !ALU_BYTE_I |=>
		FLAGS_O[3] == $past(ALU_RESULT_I[15]))
		else $error("sign flag does not match result");
	chk_carry_ovf: assert property (ALU_UPD_I |=>
		FLAGS_O[0] == $past(ALU_CARRY_I) && FLAGS_O[5] == $past(ALU_OVF_I))
		else $error("carry or overflow not captured");
	chk_mask_block: assert property (IRQ_MASKABLE_I && !FLAGS_O[6] |-> !IRQ_ACCEPT_O)
		else $error("maskable interrupt accepted while disabled");
	chk_prio_level: assert property (IRQ_ACCEPT_O |-> IRQ_LEVEL_I > FLAGS_O[10:8])
		else $error("interrupt accepted at or below processor level");
	chk_pc_load: assert property (PC_LOAD_I |=> PC_O == $past(PC_NEXT_I))
		else $error("program counter not loaded");
	chk_bank_write: assert property (CORE_WE_I && CORE_SEL_I == 4'h0 &&
		CORE_BYTE_I == 2'h0 && !FLAG_WE_I && !apb_wr |=>
		LONG_DATA_LOW_O[15:0] == $past(CORE_WDATA_I[15:0]))
		else $error("word write missed the selected bank");

	cov_irq_ack: cover property (IRQ_ACCEPT_O ##1 IRQ_ACK_I);
	cov_swi_high: cover property (SWI_EXEC_I && !swi_low && stack_sel);
	cov_bank_flip: cover property ($changed(bank_sel));
	cov_long_write: cover property (CORE_LONG_WE_I && CORE_LONG_SEL_I == 2'h2);
endmodule : crf_regfile
`default_nettype wire

// >>> verification/crf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Core-side sequencer stand-in
// ----------------------------------------
module crf_core_model (
	input wire logic clk_i,
	output logic we_o,
	output logic [3:0] sel_o,
	output logic [1:0] byte_o,
	output logic [19:0] wd_o,
	output logic [3:0] rsel_o,
	output logic lwe_o,
	output logic [1:0] lsel_o,
	output logic [31:0] lwd_o,
	output logic pcl_o,
	output logic [19:0] pcn_o,
	output logic fwe_o,
	output logic [10:0] fwd_o,
	output logic upd_o,
	output logic aby_o,
	output logic [15:0] res_o,
	output logic car_o,
	output logic ovf_o,
	output logic irq_o,
	output logic imsk_o,
	output logic [2:0] lvl_o,
	output logic ack_o,
	output logic swi_o,
	output logic [5:0] swn_o
);
	initial
	begin
		{we_o, sel_o, byte_o, wd_o, rsel_o, lwe_o, lsel_o, lwd_o, pcl_o, pcn_o} = '0;
		{fwe_o, fwd_o, upd_o, aby_o, res_o, car_o, ovf_o, irq_o, imsk_o, lvl_o} = '0;
		{ack_o, swi_o, swn_o} = '0;
	end
	// Released data lines of wr, lw, pc and alu show inverted junk; fl and swip leave the old value
	task automatic wr(input logic [3:0] s, input logic [1:0] b, input logic [19:0] d);
		@(posedge clk_i);
		we_o <= 1'h1;
		sel_o <= s;
		byte_o <= b;
		wd_o <= d;
		@(posedge clk_i);
		we_o <= 1'h0;
		wd_o <= ~d;
	endtask : wr
	task automatic lw(input logic [1:0] s, input logic [31:0] d);
		@(posedge clk_i);
		lwe_o <= 1'h1;
		lsel_o <= s;
		lwd_o <= d;
		@(posedge clk_i);
		lwe_o <= 1'h0;
		lwd_o <= ~d;
	endtask : lw
	task automatic rd(input logic [3:0] s);
		@(posedge clk_i);
		rsel_o <= s;
		@(posedge clk_i);
	endtask : rd
	task automatic pc(input logic [19:0] d);
		@(posedge clk_i);
		pcl_o <= 1'h1;
		pcn_o <= d;
		@(posedge clk_i);
		pcl_o <= 1'h0;
		pcn_o <= ~d;
	endtask : pc
	task automatic fl(input logic [10:0] v);
		@(posedge clk_i);
		fwe_o <= 1'h1;
		fwd_o <= v & 11'h7FD;
		@(posedge clk_i);
		fwe_o <= 1'h0;
	endtask : fl
	task automatic alu(input logic b, input logic [15:0] r, input logic c, input logic o);
		@(posedge clk_i);
		{upd_o, aby_o, res_o, car_o, ovf_o} <= {1'h1, b, r, c, o};
		@(posedge clk_i);
		upd_o <= 1'h0;
		res_o <= ~r;
	endtask : alu
	task automatic ackp();
		@(posedge clk_i);
		ack_o <= 1'h1;
		@(posedge clk_i);
		ack_o <= 1'h0;
	endtask : ackp
	task automatic swip(input logic [5:0] n);
		@(posedge clk_i);
		swi_o <= 1'h1;
		swn_o <= n;
		@(posedge clk_i);
		swi_o <= 1'h0;
	endtask : swip
	task automatic irq(input logic q, input logic m, input logic [2:0] l);
		@(posedge clk_i);
		{irq_o, imsk_o, lvl_o} <= {q, m, l};
	endtask : irq
endmodule : crf_core_model
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd, ldl, ldh, lad, lwd, rv;
	logic prdy, perr, acc, re, we, lwe, pcl, fwe, upd, aby, car, ovf, irq, imsk, ack, swi;
	logic [19:0] cdat, pco, vbo, wd, pcn;
	logic [15:0] sbo, fbo, spo, res;
	logic [10:0] processor_flags, fwd;
	logic [3:0] sel, rsel;
	logic [1:0] bsel, lsel;
	logic [2:0] lvl;
	logic [5:0] swn;
	int err_total = 0;
	int comparisons = 0;
	crf_regfile uut (
		.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.CORE_WE_I(we), .CORE_SEL_I(sel), .CORE_BYTE_I(bsel), .CORE_WDATA_I(wd),
		.CORE_RSEL_I(rsel), .CORE_RDATA_O(cdat), .CORE_LONG_WE_I(lwe),
		.CORE_LONG_SEL_I(lsel), .CORE_LONG_WDATA_I(lwd), .PC_LOAD_I(pcl), .PC_NEXT_I(pcn),
		.FLAG_WE_I(fwe), .FLAG_WDATA_I(fwd), .ALU_UPD_I(upd), .ALU_BYTE_I(aby),
		.ALU_RESULT_I(res), .ALU_CARRY_I(car), .ALU_OVF_I(ovf), .IRQ_REQ_I(irq),
		.IRQ_MASKABLE_I(imsk), .IRQ_LEVEL_I(lvl), .IRQ_ACCEPT_O(acc), .IRQ_ACK_I(ack),
		.SWI_EXEC_I(swi), .SWI_NUM_I(swn), .FLAGS_O(processor_flags), .PC_O(pco), .VECTOR_BASE_O(vbo),
		.STATIC_BASE_O(sbo), .FRAME_BASE_O(fbo), .ACTIVE_SP_O(spo), .LONG_DATA_LOW_O(ldl),
		.LONG_DATA_HIGH_O(ldh), .LONG_ADDR_O(lad)
	);
	crf_core_model core (
		.clk_i(clk), .we_o(we), .sel_o(sel), .byte_o(bsel), .wd_o(wd), .rsel_o(rsel),
		.lwe_o(lwe), .lsel_o(lsel), .lwd_o(lwd), .pcl_o(pcl), .pcn_o(pcn), .fwe_o(fwe),
		.fwd_o(fwd), .upd_o(upd), .aby_o(aby), .res_o(res), .car_o(car), .ovf_o(ovf),
		.irq_o(irq), .imsk_o(imsk), .lvl_o(lvl), .ack_o(ack), .swi_o(swi), .swn_o(swn)
	);
	always #5 clk = ~clk;
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Waits for ready; only the watchdog ends a stuck wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwr, padr, pwd} <= {1'h1, w, a, d};
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (prdy !== 1'h1)
		begin
			@(posedge clk);
		end
		rv = prd;
		re = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb
	task automatic summarize();
		$display("Mismatches %0d, checks %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_reset();
		@(negedge clk);
		chk(32'(processor_flags), 32'h0000_0000);
		chk(32'(pco), 32'h0000_0000);
		chk(32'(prdy), 32'h0000_0001);
		apb(1'h0, 8'h54, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
		chk(32'(re), 32'h0000_0000);
	endtask : s_reset
	task automatic s_data();
		core.lw(crf_pkg::LSEL_DATA_HIGH, 32'h9ABC_1111);
		core.lw(crf_pkg::LSEL_DATA_LOW, 32'h5678_0000);
		core.wr(crf_pkg::IDX_DATA0, crf_pkg::BYTE_WORD, 20'h0_1234);
		core.wr(crf_pkg::IDX_DATA1, crf_pkg::BYTE_LOW, 20'h0_00AB);
		core.wr(crf_pkg::IDX_DATA1, crf_pkg::BYTE_HIGH, 20'h0_00CD);
		core.lw(crf_pkg::LSEL_ADDR, 32'hA1A1_A0A0);
		core.rd(crf_pkg::IDX_DATA1);
		@(negedge clk);
		chk(ldl, 32'h5678_1234);
		chk(ldh, 32'h9ABC_CDAB);
		chk(lad, 32'hA1A1_A0A0);
		chk(32'(cdat), 32'h0000_CDAB);
		apb(1'h0, 8'h0C, 32'h0000_0000);
		chk(rv, 32'h0000_9ABC);
		apb(1'h0, 8'h14, 32'h0000_0000);
		chk(rv, 32'h0000_A1A1);
	endtask : s_data
	task automatic s_bank();
		core.wr(crf_pkg::IDX_FRAME, crf_pkg::BYTE_WORD, 20'h3_0F0B);
		core.pc(20'hA_BCDE);
		apb(1'h1, 8'h54, 32'h0000_0010);
		@(negedge clk);
		chk(32'(fbo), 32'h0000_0000);
		chk(ldl, 32'h0000_0000);
		core.wr(crf_pkg::IDX_FRAME, crf_pkg::BYTE_WORD, 20'h0_1F1B);
		@(negedge clk);
		chk(32'(fbo), 32'h0000_1F1B);
		chk(32'(pco), 32'h000A_BCDE);
		apb(1'h0, 8'h18, 32'h0000_0000);
		chk(rv, 32'h0000_0F0B);
		apb(1'h0, 8'h38, 32'h0000_0000);
		chk(rv, 32'h0000_1F1B);
		apb(1'h1, 8'h54, 32'h0000_0000);
		@(negedge clk);
		chk(32'(fbo), 32'h0000_0F0B);
		chk(ldl, 32'h5678_1234);
	endtask : s_bank
	task automatic s_stack();
		logic [5:0] nums [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
		apb(1'h1, 8'h48, 32'h0000_1111);
		apb(1'h1, 8'h4C, 32'h0000_2222);
		apb(1'h1, 8'h54, 32'h0000_00C0);
		@(negedge clk);
		chk(32'(spo), 32'h0000_1111);
		core.ackp();
		@(negedge clk);
		chk(32'(processor_flags), 32'h0000_0000);
		chk(32'(spo), 32'h0000_2222);
		core.wr(crf_pkg::IDX_SP, crf_pkg::BYTE_WORD, 20'h0_3333);
		apb(1'h0, 8'h4C, 32'h0000_0000);
		chk(rv, 32'h0000_3333);
		apb(1'h0, 8'h58, 32'h0000_0000);
		chk(rv, 32'h0000_3333);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'h1, 8'h54, 32'h0000_00C0);
			core.swip(nums[i]);
			@(negedge clk);
			chk(32'(processor_flags), (nums[i] < 6'h20) ? 32'h0000_0000 : 32'h0000_0080);
		end
	endtask : s_stack
	task automatic s_alu();
		logic [15:0] r [5] = '{16'h0000, 16'h8000, 16'h0100, 16'h0080, 16'h0001};
		logic [2:0] bco [5] = '{3'h2, 3'h1, 3'h4, 3'h7, 3'h0};
		logic [10:0] ex [5] = '{11'h045, 11'h068, 11'h044, 11'h069, 11'h040};
		core.fl(11'h042);
		for (int i = 0; i < 5; i++)
		begin
			core.alu(bco[i][2], r[i], bco[i][1], bco[i][0]);
			@(negedge clk);
			chk(32'(processor_flags), 32'(ex[i]));
		end
	endtask : s_alu
	task automatic s_irq();
		logic [10:0] f [6] = '{11'h300, 11'h300, 11'h300, 11'h340, 11'h340, 11'h740};
		logic [2:0] l [6] = '{3'h7, 3'h4, 3'h3, 3'h4, 3'h3, 3'h7};
		logic [5:0] m = 6'h19;
		logic [5:0] e = 6'h0A;
		for (int i = 0; i < 6; i++)
		begin
			apb(1'h1, 8'h54, 32'(f[i]));
			core.irq(1'h1, m[i], l[i]);
			@(negedge clk);
			chk(32'(acc), 32'(e[i]));
		end
		core.irq(1'h0, 1'h0, 3'h0);
	endtask : s_irq
	task automatic s_wide();
		apb(1'h1, 8'h40, 32'hFFFF_FFFF);
		apb(1'h0, 8'h40, 32'h0000_0000);
		chk(rv, 32'h000F_FFFF);
		chk(32'(vbo), 32'h000F_FFFF);
		apb(1'h1, 8'h50, 32'h0000_5B5B);
		core.pc(20'h1_2345);
		@(negedge clk);
		chk(32'(sbo), 32'h0000_5B5B);
		chk(32'(pco), 32'h0001_2345);
		apb(1'h1, 8'h54, 32'h0000_07FD);
		apb(1'h0, 8'h54, 32'h0000_0000);
		chk(rv, 32'h0000_07FD);
		apb(0, 8'h5C, 32'h0000_0000);
		chk(32'(re), 32'h0000_0001);
		apb(0, 8'h41, 32'h0000_0000);
		chk(32'(re), 32'h0000_0001);
		apb(1'h1, 8'h54, 32'h0000_0000);
	endtask : s_wide
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		s_reset();
		s_data();
		s_bank();
		s_stack();
		s_alu();
		s_irq();
		s_wide();
		summarize();
	end
	initial
	begin
		#200000;
		err_total++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
